// ===== logic/adc_status_cal_regs.vh
// Register addresses, field positions and reset values of the converter status and calibration registers.
`ifndef ADC_STATUS_CAL_REGS_VH
`define ADC_STATUS_CAL_REGS_VH
// ==========================================================
// Addresses
`define ADDR_STATUS      8'hE8
`define ADDR_OFFSET_HIGH 8'hBC
`define ADDR_OFFSET_MID  8'hBB
`define ADDR_OFFSET_LOW  8'hBA
`define ADDR_GAIN_HIGH   8'hAD
`define ADDR_GAIN_MID    8'hAC
// ==========================================================
// Status fields
`define BIT_BUSY      7
`define BIT_CAL_BUSY  6
`define BIT_DONE      5
`define BIT_MAIN_CLIP 4
`define BIT_FAST_CLIP 3
`define BIT_CAL_DONE  2
`define BIT_ERROR     1
`define BIT_OVERRUN   0
// ==========================================================
// Calibration load selects
`define SEL_OFFSET_HIGH 3'h0
`define SEL_OFFSET_MID  3'h1
`define SEL_OFFSET_LOW  3'h2
`define SEL_GAIN_HIGH   3'h3
`define SEL_GAIN_MID    3'h4
// ==========================================================
// Reset values
`define RESET_BYTE      8'h00
`define RESET_GAIN_HIGH 8'h80
`endif

// ===== logic/adc_status_cal_regs.v
// Converter status register and calibration byte registers on the special-function register bus.
`timescale 1ns/1ps
`include "adc_status_cal_regs.vh"
module adc_status_cal_regs #(
  parameter [7:0] GAIN_HIGH_RESET = `RESET_GAIN_HIGH
) (
  // ==========================================================
  // Clock and reset
  input  wire       mclk,
  input  wire       srst,
  // ==========================================================
  // Register bus
  input  wire [7:0] sfrAddr,
  input  wire       sfrWrite,
  input  wire [7:0] sfrWriteData,
  input  wire       bitWrite,
  input  wire [2:0] bitIndex,
  input  wire       bitValue,
  input  wire       sfrRead,
  output reg  [7:0] sfrReadData,
  output reg        sfrReadHit,
  // ==========================================================
  // Converter status inputs
  input  wire       convBusy,
  input  wire       calBusy,
  input  wire       convDoneEvent,
  input  wire       mainClipEvent,
  input  wire       fastClipEvent,
  input  wire       calDoneEvent,
  input  wire       errorEvent,
  input  wire       overrunEvent,
  // ==========================================================
  // Calibration engine
  input  wire       calLoad,
  input  wire [2:0] calLoadSel,
  input  wire [7:0] calLoadData,
  // ==========================================================
  // Calibration values
  output reg  [23:0] offset_cal_value,
  output reg  [15:8] gain_cal_value
);
  // ==========================================================
  // Decode helpers
  // One address compare serves the status and calibration-byte write decodes alike.
  function addrHit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addrHit = (addr == target);
    end
  endfunction

  // Calibration loads take priority over a same-cycle software write.
  // The engine owns the value while it runs, so its result must not be lost.
  function [7:0] nextByte;
    input [7:0] cur;
    input [7:0] target;
    input [2:0] sel;
    input       wrEn;
    input [7:0] wrAddr;
    input [7:0] wrData;
    input       ldEn;
    input [2:0] ldSel;
    input [7:0] ldData;
    begin
      nextByte = cur;
      if (wrEn && addrHit(wrAddr, target)) begin
        nextByte = wrData;
      end
      if (ldEn && (ldSel == sel)) begin
        nextByte = ldData;
      end
    end
  endfunction

  // Unmapped addresses read as zero.
  function [7:0] readMux;
    input [7:0]  addr;
    input [7:0]  status;
    input [23:0] offset;
    input [7:0]  gainHigh;
    input [7:0]  gainMid;
    begin
      case (addr)
        `ADDR_STATUS: begin
          readMux = status;
        end
        `ADDR_OFFSET_HIGH: begin
          readMux = offset[23:16];
        end
        `ADDR_OFFSET_MID: begin
          readMux = offset[15:8];
        end
        `ADDR_OFFSET_LOW: begin
          readMux = offset[7:0];
        end
        `ADDR_GAIN_HIGH: begin
          readMux = gainHigh;
        end
        `ADDR_GAIN_MID: begin
          readMux = gainMid;
        end
        default: begin
          readMux = `RESET_BYTE;
        end
      endcase
    end
  endfunction

  // ==========================================================
  // Status register
  // The busy bits are read-only views; the other six are sticky and software-writable.
  // Hardware set wins over a software clear in the same cycle, so no event is lost.
  reg  [7:0] converter_status;
  reg  [7:0] events;
  reg  [7:0] swValue;
  reg  [7:0] next_status;
  wire       hitStatus;

  assign hitStatus = addrHit(sfrAddr, `ADDR_STATUS);

  always @* begin
    events                 = `RESET_BYTE;
    events[`BIT_DONE]      = convDoneEvent;
    events[`BIT_MAIN_CLIP] = mainClipEvent;
    events[`BIT_FAST_CLIP] = fastClipEvent;
    events[`BIT_CAL_DONE]  = calDoneEvent;
    events[`BIT_ERROR]     = errorEvent;
    events[`BIT_OVERRUN]   = overrunEvent;
  end

  always @* begin
    swValue = converter_status;
    if (hitStatus && sfrWrite) begin
      swValue = sfrWriteData;
    end else if (hitStatus && bitWrite) begin
      swValue[bitIndex] = bitValue;
    end
  end

  always @* begin
    next_status                = swValue | events;
    next_status[`BIT_BUSY]     = convBusy;
    next_status[`BIT_CAL_BUSY] = calBusy;
  end

  always @(posedge mclk) begin
    if (srst) begin
      converter_status <= `RESET_BYTE;
    end else begin
      converter_status <= next_status;
    end
  end

  // ==========================================================
  // Calibration bytes
  // Each byte reads back exactly what was last written or loaded.
  reg  [7:0] gain_cal_high_byte;
  reg  [7:0] next_offsetHigh;
  reg  [7:0] next_offsetMid;
  reg  [7:0] next_offsetLow;
  reg  [7:0] next_gainHigh;
  reg  [7:0] next_gainMid;

  always @* begin
    next_offsetHigh = nextByte(offset_cal_value[23:16], `ADDR_OFFSET_HIGH, `SEL_OFFSET_HIGH,
                               sfrWrite, sfrAddr, sfrWriteData, calLoad, calLoadSel, calLoadData);
    next_offsetMid  = nextByte(offset_cal_value[15:8], `ADDR_OFFSET_MID, `SEL_OFFSET_MID,
                               sfrWrite, sfrAddr, sfrWriteData, calLoad, calLoadSel, calLoadData);
    next_offsetLow  = nextByte(offset_cal_value[7:0], `ADDR_OFFSET_LOW, `SEL_OFFSET_LOW,
                               sfrWrite, sfrAddr, sfrWriteData, calLoad, calLoadSel, calLoadData);
    next_gainHigh   = nextByte(gain_cal_high_byte, `ADDR_GAIN_HIGH, `SEL_GAIN_HIGH,
                               sfrWrite, sfrAddr, sfrWriteData, calLoad, calLoadSel, calLoadData);
    next_gainMid    = nextByte(gain_cal_value, `ADDR_GAIN_MID, `SEL_GAIN_MID,
                               sfrWrite, sfrAddr, sfrWriteData, calLoad, calLoadSel, calLoadData);
  end

  always @(posedge mclk) begin
    if (srst) begin
      offset_cal_value <= {3{`RESET_BYTE}};
    end else begin
      offset_cal_value <= {next_offsetHigh, next_offsetMid, next_offsetLow};
    end
  end

  // The high gain byte comes out of reset at a part-dependent value, so it is a parameter.
  always @(posedge mclk) begin
    if (srst) begin
      gain_cal_high_byte <= GAIN_HIGH_RESET;
    end else begin
      gain_cal_high_byte <= next_gainHigh;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      gain_cal_value <= `RESET_BYTE;
    end else begin
      gain_cal_value <= next_gainMid;
    end
  end

  // ==========================================================
  // Read path
  // Registered and free of side effects, so a read never disturbs a flag or a calibration byte.
  reg  [7:0] next_readData;

  always @* begin
    next_readData = `RESET_BYTE;
    if (sfrRead) begin
      next_readData = readMux(sfrAddr, converter_status, offset_cal_value,
                              gain_cal_high_byte, gain_cal_value);
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      sfrReadData <= `RESET_BYTE;
      sfrReadHit  <= 1'b0;
    end else begin
      sfrReadData <= next_readData;
      sfrReadHit  <= sfrRead;
    end
  end
endmodule

// ===== dv/adc_regs_chk.sv
// Assertions on the ports of the register slice.
`timescale 1ns/1ps
module adc_regs_chk (
  input wire        mclk, srst, sfrWrite, sfrRead, sfrReadHit, fastClipEvent, calLoad,
  input wire [7:0]  sfrAddr, sfrReadData,
  input wire [23:0] offset_cal_value
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire [7:0]  rd = sfrRead ? sfrAddr : 8'h00;
  wire [23:0] ov = offset_cal_value;
  a_idle_read: assert property (!sfrRead |=> !sfrReadHit && !sfrReadData) else $error("Stray read.");
  a_status_hit: assert property (rd == 8'he8 |=> sfrReadHit) else $error("No read hit.");
  a_clip_seen: assert property (fastClipEvent ##1 rd == 8'he8 |=> sfrReadData[3]) else $error("No clip.");
  a_low_read: assert property (rd == 8'hba |=> sfrReadData == $past(ov[7:0])) else $error("Low byte.");
  a_mid_read: assert property (rd == 8'hbb |=> sfrReadData == $past(ov[15:8])) else $error("Mid byte.");
  a_high_read: assert property (rd == 8'hbc |=> sfrReadData == $past(ov[23:16])) else $error("High byte.");
  a_offset_hold: assert property (!sfrWrite && !calLoad |=> $stable(ov)) else $error("Offset moved.");
  a_stray_write: assert property (sfrWrite && !calLoad && sfrAddr == 8'hab |=> $stable(ov)) else $error("Stray write.");
  cover property (fastClipEvent ##1 rd == 8'he8);
  cover property (calLoad);
  cover property (sfrWrite && sfrAddr == 8'hab);
endmodule
bind adc_status_cal_regs adc_regs_chk chk (.*);

// ===== dv/sfr_core_model.sv
// Core-side model of the register bus, driving on falling edges.
`timescale 1ns/1ps
module sfr_core_model (
  input wire       mclk, sfrReadHit,
  input wire [7:0] sfrReadData,
  output reg       sfrWrite = 1'b0, bitWrite = 1'b0, bitValue = 1'b0, sfrRead = 1'b0,
  output reg [2:0] bitIndex = 3'h0,
  output reg [7:0] sfrAddr = 8'h00, sfrWriteData = 8'h00
);
  reg [8:0] q;
  // Idle bus shows inverted values, so a stale address is never taken for a request.
  task xfer(input [1:0] k, input [7:0] a, d);
    @(negedge mclk) {sfrAddr, sfrWriteData, bitIndex, bitValue} = {a, d, d[3:0]};
    {sfrRead, sfrWrite, bitWrite} = {k == 2'd0, k == 2'd1, k == 2'd2};
    @(negedge mclk) {sfrAddr, sfrWriteData, sfrRead, sfrWrite, bitWrite} = {~a, ~d, 3'b000};
    q = {sfrReadHit, sfrReadData};
  endtask
endmodule

// ===== dv/adc_status_cal_regs_tb_top.sv
// Self-checking bench of the status and calibration register slice.
`timescale 1ns/1ps
`define CHK(g,e) begin cmpCount++; if (g !== e) begin errCount++; $display("MISMATCH %0t %h %h",$time,g,e); end end
module adc_status_cal_regs_tb_top;
  localparam [47:0] AD = 48'hbcbb_baad_ace8;
  reg         mclk = 1'b0, srst = 1'b1, calLoad = 1'b0, convBusy = 1'b0, calBusy = 1'b0;
  reg  [5:0]  ev = 6'h00;
  reg  [2:0]  calLoadSel = 3'h0;
  reg  [7:0]  calLoadData = 8'h00;
  wire [7:0]  sfrAddr, sfrWriteData, sfrReadData;
  wire [2:0]  bitIndex;
  wire        sfrWrite, bitWrite, bitValue, sfrRead, sfrReadHit;
  wire [23:0] offset_cal_value;
  wire [15:8] gain_cal_value;
  int         errCount = 0, cmpCount = 0, cyc = 0, i;
  adc_status_cal_regs uut (.*, .convDoneEvent(ev[5]), .mainClipEvent(ev[4]),
    .fastClipEvent(ev[3]), .calDoneEvent(ev[2]), .errorEvent(ev[1]), .overrunEvent(ev[0]));
  sfr_core_model core (.*);
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) if (cyc++ == 999) testDone(1);
  task testDone(input int extra);
    errCount += extra;
    if (errCount == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tRegs;
    for (i = 1; i < 6; i++) begin
      core.xfer(0, AD[i*8+:8], 8'h00);
      `CHK(core.q, {1'b1, i == 2 ? 8'h80 : 8'h00})
      core.xfer(1, AD[i*8+:8], AD[i*8+:8] ^ 8'h5a);
      core.xfer(0, AD[i*8+:8], 8'h00);
      `CHK(core.q, {1'b1, AD[i*8+:8] ^ 8'h5a})
    end
    core.xfer(1, 8'hab, 8'h11);
    `CHK({offset_cal_value, gain_cal_value}, 32'he6e1_e0f6)
    {calLoad, calLoadSel, calLoadData} = {1'b1, 3'h2, 8'h3c};
    @(negedge mclk) {calLoadSel, calLoadData} = {3'h4, 8'hc3};
    @(negedge mclk) calLoad = 1'b0;
    `CHK({offset_cal_value[7:0], gain_cal_value}, 16'h3cc3)
    fork
      core.xfer(1, 8'hbc, 8'h55);
      begin
        @(negedge mclk) {calLoad, calLoadSel, calLoadData} = {1'b1, 3'h0, 8'ha5};
        @(negedge mclk) calLoad = 1'b0;
      end
    join
    `CHK(offset_cal_value[23:16], 8'ha5)
    srst = 1'b1;
    @(negedge mclk) srst = 1'b0;
    `CHK({offset_cal_value, gain_cal_value}, 32'h0000_0000)
    core.xfer(0, 8'had, 8'h00);
    `CHK(core.q, 9'h180)
  endtask
  task tStat;
    @(negedge mclk) ev = 6'h08;
    @(negedge mclk) ev = 6'h00;
    core.xfer(0, 8'he8, 8'h00);
    `CHK(core.q, 9'h108)
    fork
      core.xfer(2, 8'he8, 8'h06);
      begin
        @(negedge mclk) ev = 6'h08;
        @(negedge mclk) ev = 6'h00;
      end
    join
    core.xfer(0, 8'he8, 8'h00);
    `CHK(core.q, 9'h108)
    core.xfer(2, 8'he8, 8'h06);
    core.xfer(0, 8'he8, 8'h00);
    `CHK(core.q, 9'h100)
    {convBusy, calBusy, ev} = 8'hf7;
    @(negedge mclk) ev = 6'h00;
    core.xfer(2, 8'he8, 8'h0e);
    core.xfer(0, 8'he8, 8'h00);
    `CHK(core.q, 9'h1f7)
    core.xfer(1, 8'he8, 8'h00);
    core.xfer(0, 8'he8, 8'h00);
    `CHK(core.q, 9'h1c0)
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    tStat;
    tRegs;
    testDone(0);
  end
endmodule
